// >>> dbm_pkg.sv
// constants and types for the dual bridge motor control logic
package dbm_pkg;
  // clock rate in kHz (125 MHz)
  localparam int unsigned CLK_KHZ = 125000;
  // chopping off-time, in ns
  localparam int unsigned CHOP_OFF_NS = 20000;
  // blanking time after output enable, in ns
  localparam int unsigned BLANK_NS = 3750;
  // overcurrent filter time, in ns
  localparam int unsigned OC_FILTER_NS = 2300;
  // overcurrent retry period, in ns
  localparam int unsigned OC_RETRY_NS = 1400000;
  // standby entry and wake delays, in ns (not printed; plain defaults)
  localparam int unsigned STBY_ENTRY_NS = 1000;
  localparam int unsigned WAKE_NS = 1000;
  // dead time between switching transistors, in ns (plain default)
  localparam int unsigned DEAD_NS = 100;
  // least times round up, longest times round down
  localparam int unsigned CHOP_OFF_CYC = (CHOP_OFF_NS * 125 + 999) / 1000;
  localparam int unsigned BLANK_CYC = (BLANK_NS * 125 + 999) / 1000;
  localparam int unsigned OC_FILTER_CYC = (OC_FILTER_NS * 125) / 1000;
  localparam int unsigned OC_RETRY_CYC = (OC_RETRY_NS / 1000) * 125;
  localparam int unsigned STBY_ENTRY_CYC = (STBY_ENTRY_NS * 125 + 999) / 1000;
  localparam int unsigned WAKE_CYC = (WAKE_NS * 125 + 999) / 1000;
  localparam int unsigned DEAD_CYC = (DEAD_NS * 125 + 999) / 1000;
  // counter width for every interval
  localparam int unsigned CNT_W = 18;
  // output drive codes: {high side on, low side on}
  localparam logic [1:0] DRV_Z = 2'h0;
  localparam logic [1:0] DRV_L = 2'h1;
  localparam logic [1:0] DRV_H = 2'h2;
  // device mode
  typedef enum logic [1:0] {
    DBM_ACTIVE,
    DBM_ENTERING,
    DBM_STANDBY,
    DBM_WAKING
  } dbm_mode_t;
  // per-bridge protection phase
  typedef enum logic [1:0] {
    DBM_RUN,
    DBM_OC_OFF
  } dbm_oc_t;
endpackage

// >>> dbm_bridge_ctrl.sv
// dual bridge motor control logic: decode, chopping, standby, protection
`timescale 1ns/1ns
// Operation
// - decode control pair into coast/fwd/rev/brake
// - fast decay all off; slow decay lows on
// - chopping stays active under external pwm
// - threshold reached: slow decay for off-time
// - ignore sense during blanking after enable
// - comparator flags 200mV sense threshold
// - standby low: outputs off, logic reset
// - standby entered after entry delay
// - wake delay before outputs change
// - filtered overcurrent shuts bridge, flags fault
// - retry period re-enables bridge, releases flag
// - overcurrent disables only its own bridge
// - separate high/low side overcurrent inputs
// - thermal shutdown all off, auto resume
// - supply low resets logic, no flag
// - dead time between transistor switching
module dbm_bridge_ctrl #(
  parameter int unsigned CHOP_OFF_CYC = dbm_pkg::CHOP_OFF_CYC,
  parameter int unsigned BLANK_CYC = dbm_pkg::BLANK_CYC,
  parameter int unsigned OC_FILTER_CYC = dbm_pkg::OC_FILTER_CYC,
  parameter int unsigned OC_RETRY_CYC = dbm_pkg::OC_RETRY_CYC,
  parameter int unsigned STBY_ENTRY_CYC = dbm_pkg::STBY_ENTRY_CYC,
  parameter int unsigned WAKE_CYC = dbm_pkg::WAKE_CYC,
  parameter int unsigned DEAD_CYC = dbm_pkg::DEAD_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bridge_a_ctrl_1_i,
  input wire logic bridge_a_ctrl_2_i,
  input wire logic bridge_b_ctrl_1_i,
  input wire logic bridge_b_ctrl_2_i,
  input wire logic standby_request_n_i,
  input wire logic [1:0] chop_trip_i,
  input wire logic [1:0] oc_high_side_i,
  input wire logic [1:0] oc_low_side_i,
  input wire logic thermal_trip_i,
  input wire logic supply_low_i,
  output logic [1:0] bridge_a_out_1_o,
  output logic [1:0] bridge_a_out_2_o,
  output logic [1:0] bridge_b_out_1_o,
  output logic [1:0] bridge_b_out_2_o,
  output logic protection_flag_n_o,
  output logic protection_flag_n_oe_o
);

  // ************************************************
  // mode control
  // ************************************************

  // typed last counts (cycle count minus one)
  localparam logic [dbm_pkg::CNT_W-1:0] ENTRY_LAST =
    dbm_pkg::CNT_W'(STBY_ENTRY_CYC - 1);
  localparam logic [dbm_pkg::CNT_W-1:0] WAKE_LAST =
    dbm_pkg::CNT_W'(WAKE_CYC - 1);

  dbm_pkg::dbm_mode_t mode_ff; // device mode
  dbm_pkg::dbm_mode_t nxt_mode;
  logic [dbm_pkg::CNT_W-1:0] mode_cnt_ff; // entry/wake timer
  logic [dbm_pkg::CNT_W-1:0] nxt_mode_cnt;
  wire logic [dbm_pkg::CNT_W-1:0] mode_cnt_inc =
    mode_cnt_ff + dbm_pkg::CNT_W'(1);

  // supply low acts as a reset of all logic, no fault shown
  // supply low resets
  wire logic hard_reset = reset_i | supply_low_i;
  // inner logic reset while in standby
  // standby holds reset
  wire logic core_reset = hard_reset | (mode_ff == dbm_pkg::DBM_STANDBY);
  // outputs may only drive when active or still entering standby
  wire logic drive_ok = (mode_ff == dbm_pkg::DBM_ACTIVE) ||
                        (mode_ff == dbm_pkg::DBM_ENTERING);

  // mode next state
  always_comb begin
    nxt_mode = mode_ff;
    nxt_mode_cnt = dbm_pkg::CNT_W'(0);
    unique case (mode_ff)
      dbm_pkg::DBM_ACTIVE: begin
        if (!standby_request_n_i) begin
          nxt_mode = dbm_pkg::DBM_ENTERING;
        end
      end
      dbm_pkg::DBM_ENTERING: begin
        if (standby_request_n_i) begin
          nxt_mode = dbm_pkg::DBM_ACTIVE;
        end else if (mode_cnt_ff == ENTRY_LAST) begin
          nxt_mode = dbm_pkg::DBM_STANDBY;
        end else begin
          nxt_mode_cnt = mode_cnt_inc;
        end
      end
      dbm_pkg::DBM_STANDBY: begin
        if (standby_request_n_i) begin
          nxt_mode = dbm_pkg::DBM_WAKING;
        end
      end
      dbm_pkg::DBM_WAKING: begin
        if (!standby_request_n_i) begin
          nxt_mode = dbm_pkg::DBM_STANDBY;
        end else if (mode_cnt_ff == WAKE_LAST) begin
          nxt_mode = dbm_pkg::DBM_ACTIVE;
        end else begin
          nxt_mode_cnt = mode_cnt_inc;
        end
      end
    endcase
  end

  // mode registers; reset comes up active
  always_ff @(posedge clk_i) begin
    if (hard_reset) begin
      mode_ff <= dbm_pkg::DBM_ACTIVE;
      mode_cnt_ff <= dbm_pkg::CNT_W'(0);
    end else begin
      mode_ff <= nxt_mode;
      mode_cnt_ff <= nxt_mode_cnt;
    end
  end

  // ************************************************
  // per-bridge logic
  // ************************************************

  // control inputs gathered per bridge, index 0 = bridge a
  wire logic [1:0] ctrl_1 = {bridge_b_ctrl_1_i, bridge_a_ctrl_1_i};
  wire logic [1:0] ctrl_2 = {bridge_b_ctrl_2_i, bridge_a_ctrl_2_i};
  wire logic [1:0] oc_any = oc_high_side_i | oc_low_side_i;
  logic [1:0] out_1_ff [2]; // registered pin drive
  logic [1:0] out_2_ff [2];
  logic [1:0] oc_active; // bridge in overcurrent shutdown

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bridge
      localparam logic [dbm_pkg::CNT_W-1:0] OFF_LAST =
        dbm_pkg::CNT_W'(CHOP_OFF_CYC - 1);
      localparam logic [dbm_pkg::CNT_W-1:0] BLANK_LAST =
        dbm_pkg::CNT_W'(BLANK_CYC - 1);
      localparam logic [dbm_pkg::CNT_W-1:0] FILT_LAST =
        dbm_pkg::CNT_W'(OC_FILTER_CYC - 1);
      localparam logic [dbm_pkg::CNT_W-1:0] RETRY_LAST =
        dbm_pkg::CNT_W'(OC_RETRY_CYC - 1);
      localparam logic [dbm_pkg::CNT_W-1:0] DEAD_LAST =
        dbm_pkg::CNT_W'(DEAD_CYC - 1);

      logic chop_off_ff; // in chopping off-time
      logic [dbm_pkg::CNT_W-1:0] off_cnt_ff;
      logic [dbm_pkg::CNT_W-1:0] blank_cnt_ff; // blanking timer
      logic blank_done_ff;
      logic [dbm_pkg::CNT_W-1:0] filt_cnt_ff; // overcurrent filter
      dbm_pkg::dbm_oc_t oc_ff;
      logic [dbm_pkg::CNT_W-1:0] retry_cnt_ff;
      logic [1:0] want_1_ff; // last applied drive codes
      logic [1:0] want_2_ff;
      logic [dbm_pkg::CNT_W-1:0] dead_cnt_ff;
      logic dead_ff; // inside dead time

      wire logic drv_fwd = ctrl_1[gi] & ~ctrl_2[gi];
      wire logic drv_rev = ~ctrl_1[gi] & ctrl_2[gi];
      wire logic drv_brake = ctrl_1[gi] & ctrl_2[gi];
      // driving phase is when a high side is meant to conduct
      wire logic drives = drv_fwd | drv_rev;
      // chopping applies regardless of external pwm
      wire logic chop_brake = chop_off_ff & drives;
      wire logic shut = oc_ff == dbm_pkg::DBM_OC_OFF || thermal_trip_i ||
                        !drive_ok;
      // coast all off, brake both lows on
      wire logic [1:0] dec_1 = shut ? dbm_pkg::DRV_Z :
                                (drv_brake | chop_brake) ? dbm_pkg::DRV_L :
                                drv_fwd ? dbm_pkg::DRV_H :
                                drv_rev ? dbm_pkg::DRV_L : dbm_pkg::DRV_Z;
      wire logic [1:0] dec_2 = shut ? dbm_pkg::DRV_Z :
                                (drv_brake | chop_brake) ? dbm_pkg::DRV_L :
                                drv_rev ? dbm_pkg::DRV_H :
                                drv_fwd ? dbm_pkg::DRV_L : dbm_pkg::DRV_Z;
      wire logic changed = (dec_1 != want_1_ff) || (dec_2 != want_2_ff);
      // output newly driving a high side starts blanking
      wire logic enable_edge = drives & ~shut & ~chop_off_ff & changed;
      // chop_trip_i is the 200mV comparator result
      wire logic chop_hit = chop_trip_i[gi] & blank_done_ff & drives &
                            ~chop_off_ff & ~dead_ff & ~shut;

      always_ff @(posedge clk_i) begin
        if (core_reset || !drives) begin
          chop_off_ff <= 1'b0;
          off_cnt_ff <= dbm_pkg::CNT_W'(0);
        end else if (chop_hit) begin
          chop_off_ff <= 1'b1;
          off_cnt_ff <= dbm_pkg::CNT_W'(0);
        end else if (chop_off_ff) begin
          chop_off_ff <= off_cnt_ff != OFF_LAST;
          off_cnt_ff <= off_cnt_ff + dbm_pkg::CNT_W'(1);
        end
      end

      // blanking timer, restarts on each new enable
      always_ff @(posedge clk_i) begin
        if (core_reset || enable_edge) begin
          blank_cnt_ff <= dbm_pkg::CNT_W'(0);
          blank_done_ff <= 1'b0;
        end else if (!blank_done_ff) begin
          blank_done_ff <= blank_cnt_ff == BLANK_LAST;
          blank_cnt_ff <= blank_cnt_ff + dbm_pkg::CNT_W'(1);
        end
      end

      always_ff @(posedge clk_i) begin
        if (core_reset) begin
          oc_ff <= dbm_pkg::DBM_RUN;
          filt_cnt_ff <= dbm_pkg::CNT_W'(0);
          retry_cnt_ff <= dbm_pkg::CNT_W'(0);
        end else begin
          unique case (oc_ff)
            dbm_pkg::DBM_RUN: begin
              retry_cnt_ff <= dbm_pkg::CNT_W'(0);
              if (!oc_any[gi]) begin
                filt_cnt_ff <= dbm_pkg::CNT_W'(0);
              end else if (filt_cnt_ff == FILT_LAST) begin
                oc_ff <= dbm_pkg::DBM_OC_OFF;
                filt_cnt_ff <= dbm_pkg::CNT_W'(0);
              end else begin
                filt_cnt_ff <= filt_cnt_ff + dbm_pkg::CNT_W'(1);
              end
            end
            dbm_pkg::DBM_OC_OFF: begin
              if (retry_cnt_ff == RETRY_LAST) begin
                oc_ff <= dbm_pkg::DBM_RUN;
              end else begin
                retry_cnt_ff <= retry_cnt_ff + dbm_pkg::CNT_W'(1);
              end
            end
          endcase
        end
      end

      // dead time: drive Z for a while on any change
      always_ff @(posedge clk_i) begin
        if (core_reset) begin
          want_1_ff <= dbm_pkg::DRV_Z;
          want_2_ff <= dbm_pkg::DRV_Z;
          dead_ff <= 1'b0;
          dead_cnt_ff <= dbm_pkg::CNT_W'(0);
        end else if (changed) begin
          want_1_ff <= dec_1;
          want_2_ff <= dec_2;
          dead_ff <= 1'b1;
          dead_cnt_ff <= dbm_pkg::CNT_W'(0);
        end else if (dead_ff) begin
          dead_ff <= dead_cnt_ff != DEAD_LAST;
          dead_cnt_ff <= dead_cnt_ff + dbm_pkg::CNT_W'(1);
        end
      end

      // each bridge shuts down on its own overcurrent only
      assign oc_active[gi] = oc_ff == dbm_pkg::DBM_OC_OFF;

      // registered pins; shutdowns go to Z at once, skipping dead time
      // standby forces Z
      always_ff @(posedge clk_i) begin
        if (core_reset || shut || dead_ff || changed) begin
          out_1_ff[gi] <= dbm_pkg::DRV_Z;
          out_2_ff[gi] <= dbm_pkg::DRV_Z;
        end else begin
          out_1_ff[gi] <= want_1_ff;
          out_2_ff[gi] <= want_2_ff;
        end
      end
    end
  endgenerate

  // ************************************************
  // fault flag
  // ************************************************

  logic flag_oe_ff; // pulling the flag low

  always_ff @(posedge clk_i) begin
    if (core_reset) begin
      flag_oe_ff <= 1'b0;
    end else begin
      flag_oe_ff <= (|oc_active) | thermal_trip_i;
    end
  end

  assign bridge_a_out_1_o = out_1_ff[0];
  assign bridge_a_out_2_o = out_2_ff[0];
  assign bridge_b_out_1_o = out_1_ff[1];
  assign bridge_b_out_2_o = out_2_ff[1];
  // pin only ever pulls low
  assign protection_flag_n_o = 1'b0;
  assign protection_flag_n_oe_o = flag_oe_ff;

endmodule

// >>> dbm_ctrl_model.sv
// controller model: drives one bridge's control pair with pwm
`timescale 1ns/1ns
// ********************************
// motion controller model
// ********************************
module dbm_ctrl_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic fwd_i,
  input wire logic slow_i,
  input wire logic pwm_i,
  output logic ctrl_1_o,
  output logic ctrl_2_o
);
  logic c1_ff; // first control input
  logic c2_ff; // second control input
  // fast decay: pwm on one input, other low
  // slow decay: one input high, pwm on other
  wire nxt_c1 = slow_i ? (fwd_i | pwm_i) : (fwd_i & pwm_i);
  wire nxt_c2 = slow_i ? (~fwd_i | pwm_i) : (~fwd_i & pwm_i);
  // changes only just after an edge, like a real controller
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      c1_ff <= 1'b0;
      c2_ff <= 1'b0;
    end else begin
      c1_ff <= nxt_c1;
      c2_ff <= nxt_c2;
    end
  end
  assign ctrl_1_o = c1_ff;
  assign ctrl_2_o = c2_ff;
endmodule

// >>> dbm_bridge_ctrl_chk.sv
// assertion checker on the dual bridge control ports
`timescale 1ns/1ns
// ********************************
// port checker
// ********************************
module dbm_bridge_ctrl_chk #(
  parameter int unsigned WAKE_CYC = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bridge_b_ctrl_1_i,
  input wire logic bridge_b_ctrl_2_i,
  input wire logic standby_request_n_i,
  input wire logic [1:0] oc_high_side_i,
  input wire logic [1:0] oc_low_side_i,
  input wire logic thermal_trip_i,
  input wire logic supply_low_i,
  input wire logic [1:0] bridge_a_out_1_o,
  input wire logic [1:0] bridge_a_out_2_o,
  input wire logic [1:0] bridge_b_out_1_o,
  input wire logic [1:0] bridge_b_out_2_o,
  input wire logic protection_flag_n_o,
  input wire logic protection_flag_n_oe_o
);
  // cycles awake, saturating; margin past the wake delay
  logic [4:0] up_ff;
  wire awake = (up_ff > 5'(WAKE_CYC + 4)) && standby_request_n_i
    && !supply_low_i;
  always_ff @(posedge clk_i) begin
    if (reset_i || supply_low_i || !standby_request_n_i) begin
      up_ff <= 5'h0;
    end else if (!up_ff[4]) begin
      up_ff <= up_ff + 5'h1;
    end
  end
  wire oe = protection_flag_n_oe_o; // flag pulled low
  wire a_z = {bridge_a_out_1_o, bridge_a_out_2_o} == 4'h0;
  wire all_z = a_z && ({bridge_b_out_1_o, bridge_b_out_2_o} == 4'h0);
  // brake on b with no shutdown anywhere near
  wire b_brk = awake && bridge_b_ctrl_1_i && bridge_b_ctrl_2_i && !oe
    && !oc_high_side_i[1] && !oc_low_side_i[1] && !thermal_trip_i;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_asleep;
    (!standby_request_n_i) [*8];
  endsequence
  sequence s_oc_a;
    (awake && oc_high_side_i[0]) [*6];
  endsequence
  property p_flag_od;
    protection_flag_n_o == 1'b0;
  endproperty
  a_flag_od: assert property (p_flag_od)
    else $error("flag data not low");
  property p_sup;
    supply_low_i |=> all_z && !oe;
  endproperty
  a_sup: assert property (p_sup)
    else $error("supply low left drive or flag");
  property p_therm;
    (awake && thermal_trip_i) [*2] |-> all_z && oe;
  endproperty
  a_therm: assert property (p_therm)
    else $error("thermal shutdown missing");
  property p_brake;
    b_brk [*6] |-> {bridge_b_out_1_o, bridge_b_out_2_o}
      == {dbm_pkg::DRV_L, dbm_pkg::DRV_L};
  endproperty
  a_brake: assert property (p_brake)
    else $error("brake not low on both outputs");
  property p_sleep;
    s_asleep |-> all_z;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("outputs driven in standby");
  property p_wake;
    s_asleep ##1 standby_request_n_i |=> all_z [*3];
  endproperty
  a_wake: assert property (p_wake)
    else $error("outputs changed inside wake delay");
  property p_oc_shut;
    s_oc_a |=> a_z ##1 oe;
  endproperty
  a_oc_shut: assert property (p_oc_shut)
    else $error("overcurrent shutdown missing");
  property p_oc_hold;
    $rose(oe) && !thermal_trip_i |-> (oe || !awake) [*8];
  endproperty
  a_oc_hold: assert property (p_oc_hold)
    else $error("flag released before retry");
endmodule

// >>> dual_bridge_motor_control_tb_top.sv
// self-checking bench for the dual bridge control logic
`timescale 1ns/1ns
// ********************************
// bench top
// ********************************
module dual_bridge_motor_control_tb_top;
  localparam int OFF = 40; // chop off-time, shortened
  localparam int RETRY = 50; // overcurrent retry, shortened
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sby_n = 1'b1; // standby request
  logic therm = 1'b0;
  logic sup_low = 1'b0;
  logic [1:0] chop = 2'h0;
  logic [1:0] och = 2'h0;
  logic [1:0] ocl = 2'h0;
  logic [2:0] ma = 3'h0; // model a: fwd, slow, pwm
  logic [2:0] mb = 3'h0;
  logic a1, a2, b1, b2;
  logic [1:0] ao1, ao2, bo1, bo2;
  logic fl, fl_oe;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] rs = 32'h41;
  // open-drain flag with its pull-up
  wire flag_w = fl_oe ? fl : 1'b1;
  dbm_ctrl_model ma_m (.clk_i(clk_i), .reset_i(reset_i), .fwd_i(ma[2]),
    .slow_i(ma[1]), .pwm_i(ma[0]), .ctrl_1_o(a1), .ctrl_2_o(a2));
  dbm_ctrl_model mb_m (.clk_i(clk_i), .reset_i(reset_i), .fwd_i(mb[2]),
    .slow_i(mb[1]), .pwm_i(mb[0]), .ctrl_1_o(b1), .ctrl_2_o(b2));
  dbm_bridge_ctrl #(.CHOP_OFF_CYC(OFF), .BLANK_CYC(8), .OC_FILTER_CYC(4),
    .OC_RETRY_CYC(RETRY), .STBY_ENTRY_CYC(4), .WAKE_CYC(4), .DEAD_CYC(2)
  ) dut (.clk_i(clk_i), .reset_i(reset_i), .bridge_a_ctrl_1_i(a1),
    .bridge_a_ctrl_2_i(a2), .bridge_b_ctrl_1_i(b1), .bridge_b_ctrl_2_i(b2),
    .standby_request_n_i(sby_n), .chop_trip_i(chop), .oc_high_side_i(och),
    .oc_low_side_i(ocl), .thermal_trip_i(therm), .supply_low_i(sup_low),
    .bridge_a_out_1_o(ao1), .bridge_a_out_2_o(ao2), .bridge_b_out_1_o(bo1),
    .bridge_b_out_2_o(bo2), .protection_flag_n_o(fl),
    .protection_flag_n_oe_o(fl_oe));
  // expected drive codes of a control pair
  function automatic logic [3:0] dec(input logic c1, input logic c2);
    case ({c1, c2})
      2'h0: dec = {dbm_pkg::DRV_Z, dbm_pkg::DRV_Z};
      2'h1: dec = {dbm_pkg::DRV_L, dbm_pkg::DRV_H};
      2'h2: dec = {dbm_pkg::DRV_H, dbm_pkg::DRV_L};
      default: dec = {dbm_pkg::DRV_L, dbm_pkg::DRV_L};
    endcase
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic cmp(input string nm, input logic [3:0] e,
      input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ca(input logic [3:0] e);
    cmp("bridge_a", e, {ao1, ao2});
  endtask
  task automatic cb(input logic [3:0] e);
    cmp("bridge_b", e, {bo1, bo2});
  endtask
  task automatic cf(input logic e);
    cmp("flag", {3'h0, e}, {3'h0, flag_w});
  endtask
  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // hang guard, well past the sequence length
  initial begin
    cyc(3000);
    errors++;
    final_report();
  end
  initial begin
    cyc(4);
    reset_i <= 1'b0;
    cyc(2);
    // every code and pwm mode, then random ones
    for (int i = 0; i < 28; i++) begin
      rs = xs(rs);
      ma <= (i < 8) ? i[2:0] : rs[2:0];
      mb <= (i < 8) ? ~i[2:0] : rs[5:3];
      cyc(8);
      ca(dec(a1, a2));
      cb(dec(b1, b2));
    end
    ma <= 3'h0;
    cyc(8);
    ma <= 3'h5;
    cyc(6);
    // trip inside blanking is ignored
    chop <= 2'h1;
    cyc(1);
    chop <= 2'h0;
    cyc(4);
    ca(dec(1'b1, 1'b0));
    cyc(6);
    chop <= 2'h1;
    cyc(1);
    chop <= 2'h0;
    cyc(6);
    ca(dec(1'b1, 1'b1));
    cyc(OFF - 12);
    ca(dec(1'b1, 1'b1));
    cyc(14);
    ca(dec(1'b1, 1'b0));
    mb <= 3'h3;
    cyc(12);
    och <= 2'h1;
    cyc(8);
    ca(4'h0);
    cb(dec(1'b1, 1'b1));
    cf(1'b0);
    och <= 2'h0;
    cyc(RETRY - 20);
    cf(1'b0);
    cyc(30);
    cf(1'b1);
    ca(dec(1'b1, 1'b0));
    ocl <= 2'h2;
    cyc(8);
    cb(4'h0);
    ca(dec(1'b1, 1'b0));
    ocl <= 2'h0;
    cyc(RETRY + 12);
    therm <= 1'b1;
    cyc(4);
    ca(4'h0);
    cb(4'h0);
    cf(1'b0);
    therm <= 1'b0;
    cyc(8);
    cf(1'b1);
    sby_n <= 1'b0;
    cyc(2);
    cb(dec(1'b1, 1'b1));
    cyc(8);
    ca(4'h0);
    sby_n <= 1'b1;
    cyc(5);
    cb(4'h0);
    cyc(10);
    cb(dec(1'b1, 1'b1));
    sup_low <= 1'b1;
    och <= 2'h3;
    cyc(8);
    cb(4'h0);
    cf(1'b1);
    sup_low <= 1'b0;
    och <= 2'h0;
    cyc(8);
    ca(dec(1'b1, 1'b0));
    final_report();
  end
endmodule
bind dbm_bridge_ctrl dbm_bridge_ctrl_chk #(.WAKE_CYC(WAKE_CYC)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .bridge_b_ctrl_1_i(bridge_b_ctrl_1_i),
  .bridge_b_ctrl_2_i(bridge_b_ctrl_2_i),
  .standby_request_n_i(standby_request_n_i),
  .oc_high_side_i(oc_high_side_i), .oc_low_side_i(oc_low_side_i),
  .thermal_trip_i(thermal_trip_i), .supply_low_i(supply_low_i),
  .bridge_a_out_1_o(bridge_a_out_1_o), .bridge_a_out_2_o(bridge_a_out_2_o),
  .bridge_b_out_1_o(bridge_b_out_1_o), .bridge_b_out_2_o(bridge_b_out_2_o),
  .protection_flag_n_o(protection_flag_n_o),
  .protection_flag_n_oe_o(protection_flag_n_oe_o));
